// ===== inc/pcs_pkg.sv
// constants for the pll clock synthesizer register file and dividers
// assumes a classic wishbone slave with 32-bit data, one register per word
package pcs_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL      = 8'h00;  // pll_control_register
    localparam logic [7:0] ADDR_MUL_HIGH  = 8'h04;  // multiplier_select_high
    localparam logic [7:0] ADDR_MUL_LOW   = 8'h08;  // multiplier_select_low
    localparam logic [7:0] ADDR_REF_DIV   = 8'h0C;  // reference divide factor r
    localparam logic [7:0] ADDR_LIN_MUL   = 8'h10;  // linear range multiplier l
    localparam logic [7:0] ADDR_STATUS    = 8'h14;  // lock and mode status
    // control register fields
    localparam int CTRL_ON_BIT    = 5;              // pll_on_bit
    localparam int CTRL_BCS_BIT   = 4;              // select pll output as bus clock source
    localparam int CTRL_PRE_LSB   = 2;              // prescale field p, 2 bits
    localparam int CTRL_RNG_LSB   = 0;              // oscillator_range_field e, 2 bits
    // reset values
    localparam logic [7:0]  RST_CTRL      = 8'h00;
    localparam logic [3:0]  RST_MUL_HIGH  = 4'h0;
    localparam logic [7:0]  RST_MUL_LOW   = 8'h40;
    localparam logic [7:0]  RST_REF_DIV   = 8'h01;
    localparam logic [7:0]  RST_LIN_MUL   = 8'h01;
    // nominal centre-of-range base frequency in hz
    localparam int          NOM_FREQ_HZ   = 38400;
    // bus clock after reset is the crystal clock divided by four
    localparam logic [1:0]  XTAL_BUS_DIV  = 2'h3;   // terminal count of a divide-by-4
    // lock detector: frequency windows compared over this many reference edges
    localparam logic [3:0]  LOCK_WINDOWS  = 4'h8;
    localparam logic [15:0] LOCK_TOL      = 16'h0001;
    // loop filter step sizes: acquisition is coarse, tracking is fine
    localparam logic [15:0] STEP_ACQ      = 16'h0040;
    localparam logic [15:0] STEP_TRK      = 16'h0004;
    // tuning word: mid-scale is the centre of range
    localparam logic [15:0] TUNE_MID      = 16'h8000;
endpackage

// ===== src/pcs_divider.sv
// programmable modulo divider producing a one-cycle tick every n input ticks
// assumes tick_in is synchronous to clk; a modulus of zero counts as one
`timescale 1ns/1ns
`default_nettype none
module pcs_divider (
    input  wire logic        clk,       // core clock
    input  wire logic        rst_b,     // async reset, active low
    input  wire logic        tick_in,   // one-cycle input event
    input  wire logic [15:0] modulus,   // divide factor
    output logic             tick_out   // one-cycle output event
);
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic        tick_ff;
    logic        nxt_tick;
    logic [15:0] last;

    // zero behaves as one, so the terminal count never wraps below zero
    always_comb begin
        last     = (modulus == 16'h0000) ? 16'h0000 : modulus - 16'h0001;
        nxt_cnt  = cnt_ff;
        nxt_tick = 1'b0;
        if (tick_in) begin
            if (cnt_ff >= last) begin
                nxt_cnt  = 16'h0000;
                nxt_tick = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff  <= 16'h0000;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_out = tick_ff;
endmodule
`default_nettype wire

// ===== src/pcs_top.sv
// pll clock synthesizer: registers, reference and feedback dividers, phase
// detector, digital loop filter and lock detector
// assumes crystal and oscillator inputs are asynchronous square waves that are
// slow against CORE_CLK; the analogue oscillator is modelled by its tuning word
//
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - tuning word spans half to twice the centre frequency around mid-scale
// - centre frequency reported as 38.4 kHz times l times two to the e
// - reference clock follows the crystal and is divided by r
// - oscillator divided by two to the p, then by n, gives feedback
// - phase detector pulses up or down by the edge order and gap
// - loop filter steps coarse in acquisition, fine in tracking
// - lock detector compares feedback and reference counts per reference window
// - control register holds p and e as plain binary fields
// - multiplier registers ignore writes while the pll is on
// - upper nibble of multiplier high reads zero and does nothing
// - multiplier low byte is the low byte of n
// - n of zero divides like n of one
// - multiplier low resets to 0x40, n of 64
// - reset selects crystal divided by four as bus clock
// - oscillator output runs at exactly the crystal frequency
module pcs_top (
    input  wire logic        CORE_CLK,   // 100 mhz core clock
    input  wire logic        RST_B,      // async reset, active low
    input  wire logic        XTAL_IN,    // crystal_clock pin
    input  wire logic        VCO_IN,     // oscillator_clock from the analogue core
    input  wire logic        WB_CYC_I,   // wishbone cycle
    input  wire logic        WB_STB_I,   // wishbone strobe
    input  wire logic        WB_WE_I,    // wishbone write enable
    input  wire logic [7:0]  WB_ADR_I,   // wishbone byte address
    input  wire logic [3:0]  WB_SEL_I,   // wishbone byte selects
    input  wire logic [31:0] WB_DAT_I,   // wishbone write data
    output logic      [31:0] WB_DAT_O,   // wishbone read data
    output logic             WB_ACK_O,   // wishbone acknowledge
    output logic             OSC_OUT,    // crystal clock copy
    output logic             BUS_CLK,    // selected bus clock level
    output logic             PUMP_UP,    // correction pulse: speed up
    output logic             PUMP_DN,    // correction pulse: slow down
    output logic      [15:0] TUNE,       // loop filter capacitor voltage word
    output logic             LOCKED      // lock detector output
);
    typedef enum logic [1:0] {PCS_ACQ = 2'b00, PCS_TRK = 2'b01, PCS_LCK = 2'b11} pcs_mode_t;

    // pin synchronisers: first stage feeds only the second
    logic [1:0] xs1_ff, xs2_ff, nxt_xs1, nxt_xs2;
    logic [1:0] prev_ff, nxt_prev;
    logic       x_edge, v_edge;

    always_comb begin
        nxt_xs1  = {VCO_IN, XTAL_IN};
        nxt_xs2  = xs1_ff;
        nxt_prev = xs2_ff;
    end
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            xs1_ff  <= 2'b00;
            xs2_ff  <= 2'b00;
            prev_ff <= 2'b00;
        end else begin
            xs1_ff  <= nxt_xs1;
            xs2_ff  <= nxt_xs2;
            prev_ff <= nxt_prev;
        end
    end
    assign x_edge = xs2_ff[0] & ~prev_ff[0];
    assign v_edge = xs2_ff[1] & ~prev_ff[1];

    // register file
    logic [7:0]  ctrl_ff, nxt_ctrl;
    logic [3:0]  mulh_ff, nxt_mulh;
    logic [7:0]  mull_ff, nxt_mull;
    logic [7:0]  rdiv_ff, nxt_rdiv;
    logic [7:0]  lmul_ff, nxt_lmul;
    logic        ack_ff, nxt_ack;
    logic [31:0] dat_ff, nxt_dat;
    logic        pll_on, req, wr;
    logic [1:0]  pre_p, rng_e;
    logic        lock_ff;
    pcs_mode_t   mode_ff;
    logic [31:0] centre_hz;

    assign pll_on = ctrl_ff[pcs_pkg::CTRL_ON_BIT];
    assign pre_p  = ctrl_ff[pcs_pkg::CTRL_PRE_LSB +: 2];   // binary p
    assign rng_e  = ctrl_ff[pcs_pkg::CTRL_RNG_LSB +: 2];   // binary e
    assign req    = WB_CYC_I & WB_STB_I & ~ack_ff;
    assign wr     = req & WB_WE_I & WB_SEL_I[0];
    // centre of range as l * 2^e * 38.4 khz
    assign centre_hz = (32'(lmul_ff) * 32'(pcs_pkg::NOM_FREQ_HZ)) << rng_e;

    // one-cycle ack after the request, a zero read for unmapped words
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_mulh = mulh_ff;
        nxt_mull = mull_ff;
        nxt_rdiv = rdiv_ff;
        nxt_lmul = lmul_ff;
        nxt_ack  = req;
        nxt_dat  = 32'h0000_0000;
        if (wr) begin
            unique case (WB_ADR_I)
                pcs_pkg::ADDR_CTRL:     nxt_ctrl = WB_DAT_I[7:0];
                // blocked while on, leaving the value untouched
                pcs_pkg::ADDR_MUL_HIGH: if (!pll_on) nxt_mulh = WB_DAT_I[3:0];
                pcs_pkg::ADDR_MUL_LOW:  if (!pll_on) nxt_mull = WB_DAT_I[7:0];
                pcs_pkg::ADDR_REF_DIV:  nxt_rdiv = WB_DAT_I[7:0];
                pcs_pkg::ADDR_LIN_MUL:  nxt_lmul = WB_DAT_I[7:0];
                default: ;
            endcase
        end
        if (req && !WB_WE_I) begin
            unique case (WB_ADR_I)
                pcs_pkg::ADDR_CTRL:     nxt_dat = {24'h00_0000, ctrl_ff};
                pcs_pkg::ADDR_MUL_HIGH: nxt_dat = {28'h000_0000, mulh_ff};  // [7:4] zero
                pcs_pkg::ADDR_MUL_LOW:  nxt_dat = {24'h00_0000, mull_ff};
                pcs_pkg::ADDR_REF_DIV:  nxt_dat = {24'h00_0000, rdiv_ff};
                pcs_pkg::ADDR_LIN_MUL:  nxt_dat = {24'h00_0000, lmul_ff};
                pcs_pkg::ADDR_STATUS:   nxt_dat = {centre_hz[28:0], mode_ff, lock_ff};
                default:                nxt_dat = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_ff <= pcs_pkg::RST_CTRL;        // pll off, crystal bus clock
            mulh_ff <= pcs_pkg::RST_MUL_HIGH;
            mull_ff <= pcs_pkg::RST_MUL_LOW;     // n = 64
            rdiv_ff <= pcs_pkg::RST_REF_DIV;
            lmul_ff <= pcs_pkg::RST_LIN_MUL;
            ack_ff  <= 1'b0;
            dat_ff  <= 32'h0000_0000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            mulh_ff <= nxt_mulh;
            mull_ff <= nxt_mull;
            rdiv_ff <= nxt_rdiv;
            lmul_ff <= nxt_lmul;
            ack_ff  <= nxt_ack;
            dat_ff  <= nxt_dat;
        end
    end

    // prescaler on the oscillator: one tick every 2^p oscillator edges
    logic [2:0] pre_ff, nxt_pre;
    logic       pre_tick_ff, nxt_pre_tick;
    logic [2:0] pre_last;
    always_comb begin
        pre_last     = 3'((4'h1 << pre_p) - 4'h1);
        nxt_pre      = pre_ff;
        nxt_pre_tick = 1'b0;
        if (v_edge) begin
            if (pre_ff >= pre_last) begin
                nxt_pre      = 3'h0;
                nxt_pre_tick = 1'b1;
            end else begin
                nxt_pre = pre_ff + 3'h1;
            end
        end
    end
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pre_ff      <= 3'h0;
            pre_tick_ff <= 1'b0;
        end else begin
            pre_ff      <= nxt_pre;
            pre_tick_ff <= nxt_pre_tick;
        end
    end

    // reference divider by r and feedback divider by n
    logic ref_tick, fb_tick;
    pcs_divider u_ref_div (
        .clk      (CORE_CLK),
        .rst_b    (RST_B),
        .tick_in  (x_edge),                  // buffered crystal edge
        .modulus  ({8'h00, rdiv_ff}),
        .tick_out (ref_tick)
    );
    pcs_divider u_fb_div (
        .clk      (CORE_CLK),
        .rst_b    (RST_B),
        .tick_in  (pre_tick_ff),
        .modulus  ({4'h0, mulh_ff, mull_ff}), // mull is the low byte of n
        .tick_out (fb_tick)
    );

    // phase detector, loop filter, lock detector
    logic        up_ff, dn_ff, nxt_up, nxt_dn;
    logic [15:0] tune_ff, nxt_tune, step;
    logic [15:0] fb_cnt_ff, nxt_fb_cnt;
    logic [3:0]  win_ff, nxt_win;
    pcs_mode_t   nxt_mode;
    logic        nxt_lock;
    logic [16:0] tune_sum;
    logic [15:0] fb_total;

    always_comb begin
        nxt_up = up_ff;
        nxt_dn = dn_ff;
        // first edge opens a pulse, the other edge closes it
        if (ref_tick && fb_tick) begin
            nxt_up = 1'b0;
            nxt_dn = 1'b0;
        end else if (ref_tick) begin
            nxt_up = ~dn_ff;
            nxt_dn = 1'b0;
        end else if (fb_tick) begin
            nxt_dn = ~up_ff;
            nxt_up = 1'b0;
        end
        if (!pll_on) begin
            nxt_up = 1'b0;
            nxt_dn = 1'b0;
        end
        step     = (mode_ff == PCS_ACQ) ? pcs_pkg::STEP_ACQ : pcs_pkg::STEP_TRK;
        nxt_tune = tune_ff;
        tune_sum = 17'h0_0000;
        // integrate each cycle of pulse; clamp keeps span within half..twice
        if (!pll_on) begin
            nxt_tune = pcs_pkg::TUNE_MID;
        end else if (up_ff) begin
            tune_sum = {1'b0, tune_ff} + {1'b0, step};
            nxt_tune = tune_sum[16] ? 16'hFFFF : tune_sum[15:0];
        end else if (dn_ff) begin
            nxt_tune = (tune_ff > step) ? tune_ff - step : 16'h0000;
        end
        // count feedback edges per reference window and compare
        nxt_fb_cnt = fb_tick ? fb_cnt_ff + 16'h0001 : fb_cnt_ff;
        fb_total   = nxt_fb_cnt;  // window total, kept before the counter is cleared
        nxt_win    = win_ff;
        nxt_mode   = mode_ff;
        nxt_lock   = lock_ff;
        if (!pll_on) begin
            nxt_fb_cnt = 16'h0000;
            nxt_win    = 4'h0;
            nxt_mode   = PCS_ACQ;
            nxt_lock   = 1'b0;
        end else if (ref_tick) begin
            nxt_win = win_ff + 4'h1;
            if (win_ff + 4'h1 == pcs_pkg::LOCK_WINDOWS) begin
                nxt_win    = 4'h0;
                nxt_fb_cnt = 16'h0000;
                if ((fb_total <= 16'(pcs_pkg::LOCK_WINDOWS) + pcs_pkg::LOCK_TOL) &&
                    (fb_total + pcs_pkg::LOCK_TOL >= 16'(pcs_pkg::LOCK_WINDOWS))) begin
                    nxt_mode = (mode_ff == PCS_ACQ) ? PCS_TRK : PCS_LCK;
                    nxt_lock = (mode_ff != PCS_ACQ);
                end else begin
                    nxt_mode = PCS_ACQ;  // lost frequency: back to coarse steps
                    nxt_lock = 1'b0;
                end
            end
        end
    end
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            up_ff     <= 1'b0;
            dn_ff     <= 1'b0;
            tune_ff   <= pcs_pkg::TUNE_MID;
            fb_cnt_ff <= 16'h0000;
            win_ff    <= 4'h0;
            mode_ff   <= PCS_ACQ;
            lock_ff   <= 1'b0;
        end else begin
            up_ff     <= nxt_up;
            dn_ff     <= nxt_dn;
            tune_ff   <= nxt_tune;
            fb_cnt_ff <= nxt_fb_cnt;
            win_ff    <= nxt_win;
            mode_ff   <= nxt_mode;
            lock_ff   <= nxt_lock;
        end
    end

    // bus clock: crystal divided by four unless pll selected and locked
    logic [1:0] bdiv_ff, nxt_bdiv;
    logic       bclk_ff, nxt_bclk, osc_ff, nxt_osc;
    always_comb begin
        nxt_bdiv = bdiv_ff;
        nxt_bclk = bclk_ff;
        nxt_osc  = xs2_ff[0];                           // crystal copy
        if (ctrl_ff[pcs_pkg::CTRL_BCS_BIT] && pll_on && lock_ff) begin
            nxt_bclk = fb_tick ? ~bclk_ff : bclk_ff;
        end else if (x_edge) begin
            nxt_bdiv = bdiv_ff + 2'h1;                   // divide by four
            if (bdiv_ff == pcs_pkg::XTAL_BUS_DIV || bdiv_ff == 2'h1) begin
                nxt_bclk = ~bclk_ff;
            end
        end
    end
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            bdiv_ff <= 2'h0;
            bclk_ff <= 1'b0;
            osc_ff  <= 1'b0;
        end else begin
            bdiv_ff <= nxt_bdiv;
            bclk_ff <= nxt_bclk;
            osc_ff  <= nxt_osc;
        end
    end

    assign WB_DAT_O = dat_ff;
    assign WB_ACK_O = ack_ff;
    assign OSC_OUT  = osc_ff;
    assign BUS_CLK  = bclk_ff;
    assign PUMP_UP  = up_ff;
    assign PUMP_DN  = dn_ff;
    assign TUNE     = tune_ff;
    assign LOCKED   = lock_ff;
endmodule
`default_nettype wire

// ===== tb/pcs_clk_src.sv
// far-side clock sources for pcs_top: external clock and oscillator output
// assumes both run free from time zero, as a real source does
`timescale 1ns/1ns
`default_nettype none
module pcs_clk_src #(
    parameter int XTAL_HALF_NS = 500,  // 1 mhz external clock, divided by r = 20 in the block
    parameter int VCO_HALF_NS  = 250   // 2 mhz oscillator, near l = 52 at e = 0
) (
    output logic xtal,  // crystal_clock
    output logic voltage_controlled_oscillator    // oscillator_clock
);
    // 1 mhz over r = 20 gives a 50 khz reference, inside the 30-100 khz band
    // a 30-100 khz crystal would instead run straight in with r = 1
    initial begin
        xtal = 1'b0;
        forever #(XTAL_HALF_NS) xtal = ~xtal;
    end
    // fixed oscillator: lock is judged by frequency, so the loop need not close
    initial begin
        voltage_controlled_oscillator = 1'b0;
        forever #(VCO_HALF_NS) voltage_controlled_oscillator = ~voltage_controlled_oscillator;
    end
endmodule
`default_nettype wire

// ===== tb/pcs_top_sva.sv
// checker for pcs_top: bus answer, multiplier mirror, loop outputs
// assumes it sees only the ports of every pcs_top through the bind below
`timescale 1ns/1ns
`default_nettype none
module pcs_top_sva (
    input wire logic        CORE_CLK,  // core clock
    input wire logic        RST_B,     // async reset, active low
    input wire logic        XTAL_IN,   // crystal_clock
    input wire logic        VCO_IN,    // oscillator_clock
    input wire logic        WB_CYC_I,  // cycle
    input wire logic        WB_STB_I,  // strobe
    input wire logic        WB_WE_I,   // write enable
    input wire logic [7:0]  WB_ADR_I,  // address
    input wire logic [3:0]  WB_SEL_I,  // selects
    input wire logic [31:0] WB_DAT_I,  // write data
    input wire logic [31:0] WB_DAT_O,  // read data
    input wire logic        WB_ACK_O,  // acknowledge
    input wire logic        OSC_OUT,   // crystal copy
    input wire logic        BUS_CLK,   // bus clock
    input wire logic        PUMP_UP,   // speed up
    input wire logic        PUMP_DN,   // slow down
    input wire logic [15:0] TUNE,      // loop filter word
    input wire logic        LOCKED     // lock flag
);
    logic       on_ff;   // mirror of pll_on_bit
    logic [7:0] lo_ff;   // mirror of multiplier_select_low
    logic [2:0] age_ff;  // edges since reset, saturating
    logic       wr_ok;
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_B);
    // mirrors move at the ack edge, one cycle after the block, which the idle cycle covers
    assign wr_ok = WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0];
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            on_ff  <= 1'b0;
            lo_ff  <= 8'h40;
            age_ff <= 3'h0;
        end else begin
            age_ff <= age_ff + {2'h0, age_ff != 3'h7};
            if (wr_ok && WB_ADR_I == pcs_pkg::ADDR_CTRL) on_ff <= WB_DAT_I[pcs_pkg::CTRL_ON_BIT];
            if (wr_ok && WB_ADR_I == pcs_pkg::ADDR_MUL_LOW && !on_ff) lo_ff <= WB_DAT_I[7:0];
        end
    end
    property p_ack_next; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_pulse; WB_ACK_O |-> $past(WB_CYC_I) && $past(WB_STB_I) ##1 !WB_ACK_O; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a one-cycle answer");
    property p_dat_idle; !WB_ACK_O |-> WB_DAT_O == 32'h0000_0000; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_hi_zero;
        WB_ACK_O && !WB_WE_I && WB_ADR_I == pcs_pkg::ADDR_MUL_HIGH |-> WB_DAT_O[31:4] == 28'h0;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("multiplier high upper bits set");
    property p_lo_mirror;
        WB_ACK_O && !WB_WE_I && WB_ADR_I == pcs_pkg::ADDR_MUL_LOW |-> WB_DAT_O[7:0] == lo_ff;
    endproperty
    a_lo_mirror: assert property (p_lo_mirror) else $error("multiplier low wrong");
    property p_pump_excl; !(PUMP_UP && PUMP_DN); endproperty
    a_pump_excl: assert property (p_pump_excl) else $error("both pump directions");
    property p_osc_copy; age_ff == 3'h7 |-> OSC_OUT == $past(XTAL_IN, 3); endproperty
    a_osc_copy: assert property (p_osc_copy) else $error("oscillator output not crystal");
    // a clamp at the range edge may shorten a step, so only the upper bound is firm
    property p_tune_step;
        $changed(TUNE) |-> TUNE == pcs_pkg::TUNE_MID || TUNE - $past(TUNE) <= pcs_pkg::STEP_ACQ
            || $past(TUNE) - TUNE <= pcs_pkg::STEP_ACQ;
    endproperty
    a_tune_step: assert property (p_tune_step) else $error("tune step too large");
    property p_off_quiet;
        !on_ff && !$past(on_ff) |-> TUNE == pcs_pkg::TUNE_MID && !PUMP_UP && !PUMP_DN && !LOCKED;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("loop active while off");
endmodule
bind pcs_top pcs_top_sva pcs_top_sva_i (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .XTAL_IN(XTAL_IN),
    .VCO_IN(VCO_IN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .OSC_OUT(OSC_OUT), .BUS_CLK(BUS_CLK), .PUMP_UP(PUMP_UP),
    .PUMP_DN(PUMP_DN), .TUNE(TUNE), .LOCKED(LOCKED));
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for pcs_top: register file, bus clock, lock detector
// assumes pcs_clk_src gives a 1 mhz external clock and a 2 mhz oscillator
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        clk, rst_b, cyc, stb, we, ack, osc, bclk, up, dn, lck, xtal, voltage_controlled_oscillator;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, got;
    logic [15:0] tune;
    int          errors, checked, seed, n, e;
    int          m[6];  // register model by word index; entry 5 holds status mode bits
    pcs_clk_src pcs_clk_src_i (.xtal(xtal), .voltage_controlled_oscillator(voltage_controlled_oscillator));
    pcs_top pcs_top_i (.CORE_CLK(clk), .RST_B(rst_b), .XTAL_IN(xtal), .VCO_IN(voltage_controlled_oscillator),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .OSC_OUT(osc), .BUS_CLK(bclk),
        .PUMP_UP(up), .PUMP_DN(dn), .TUNE(tune), .LOCKED(lck));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        checked++;
        if (g !== ex) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, ex, g);
        end
    endtask
    task automatic results();
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one classic cycle: held until ack is sampled, then released with an idle cycle;
    // no answer time is assumed, only the watchdog ends a hung wait
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        do @(posedge clk); while (ack !== 1'b1);
        got = rdat;
        {cyc, stb, we} <= 3'b000;
        @(posedge clk);
    endtask
    // writes only land through byte lane 0; multiplier words are frozen while on
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        bus(1'b1, a, d, s);
        if (s[0] && a < 8'h14 && a[1:0] == 2'b00 && !(m[0][5] && (a == 8'h04 || a == 8'h08)))
            m[a[4:2]] = d[7:0] & (a == pcs_pkg::ADDR_MUL_HIGH ? 8'h0F : 8'hFF);
    endtask
    // status carries the centre frequency l * 38.4 khz * 2^e above the mode bits
    function automatic logic [31:0] expv(input logic [7:0] a);
        longint c;
        c = (longint'(m[4]) * 38400) << m[0][1:0];
        if (a == pcs_pkg::ADDR_STATUS) return {c[28:0], 3'(m[5])};
        if (a < 8'h14 && a[1:0] == 2'b00) return 32'(m[a[4:2]]);
        return 32'h0000_0000;
    endfunction
    task automatic rd_all(input logic [31:0] mask);
        for (int a = 0; a <= 8'h18; a += 4) begin
            bus(1'b0, 8'(a), 32'h0000_0000, 4'hF);
            chk($sformatf("word %h", a), expv(8'(a)) & mask, got & mask);
        end
    endtask
    // counts crystal rising edges until the bus clock level changes
    task automatic tog(output int edges);
        logic b0, x0;
        b0 = bclk;
        x0 = xtal;
        edges = 0;
        for (int i = 0; i < 9000 && bclk === b0; i++) begin
            @(posedge clk);
            edges += int'(xtal && !x0);
            x0 = xtal;
        end
    endtask
    initial begin
        #1_000_000;
        errors++;
        results();
    end
    initial begin
        seed = 32'h3f7e;
        {cyc, stb, we, adr, sel, wdat} = '0;
        m = '{0, 0, 32'h0000_0040, 1, 1, 0};
        rst_b = 1'b0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rd_all(32'hFFFF_FFFF);
        tog(n);
        tog(n);
        chk("bus clock crystal edges", 32'd2, 32'(n));
        // random programming with the pll off; e stays below three
        repeat (6) begin
            e = ($random(seed) & 32'h7FFF_FFFF) % 3;
            wr(pcs_pkg::ADDR_CTRL, 32'(($random(seed) & 12) | e), 4'h1);
            wr(pcs_pkg::ADDR_LIN_MUL, $random(seed), 4'h1);
            wr(pcs_pkg::ADDR_MUL_HIGH, $random(seed), 4'h1);
            wr(pcs_pkg::ADDR_MUL_LOW, $random(seed), 4'h1);
            wr(pcs_pkg::ADDR_MUL_LOW, $random(seed), 4'hE);
            wr(8'h18, $random(seed), 4'hF);
            rd_all(32'hFFFF_FFFF);
        end
        // pll on: multiplier writes are acked yet change nothing
        wr(pcs_pkg::ADDR_CTRL, 32'h0000_0020, 4'h1);
        wr(pcs_pkg::ADDR_MUL_HIGH, $random(seed), 4'h1);
        wr(pcs_pkg::ADDR_MUL_LOW, $random(seed), 4'h1);
        rd_all(32'hFFFF_FFF8);
        // 50 khz reference against 2 mhz / (2^1 * 20): equal rates must lock
        wr(pcs_pkg::ADDR_CTRL, 32'h0000_0004, 4'h1);
        wr(pcs_pkg::ADDR_REF_DIV, 32'd20, 4'h1);
        wr(pcs_pkg::ADDR_LIN_MUL, 32'd52, 4'h1);
        wr(pcs_pkg::ADDR_MUL_HIGH, 32'd0, 4'h1);
        wr(pcs_pkg::ADDR_MUL_LOW, 32'd20, 4'h1);
        wr(pcs_pkg::ADDR_CTRL, 32'h0000_0024, 4'h1);
        for (int i = 0; i < 45000 && lck !== 1'b1; i++) @(posedge clk);
        chk("locked", 32'd1, 32'(lck));
        m[5] = 7;
        bus(1'b0, pcs_pkg::ADDR_STATUS, 32'h0000_0000, 4'hF);
        chk("status when locked", expv(pcs_pkg::ADDR_STATUS), got);
        // n = 40 halves the feedback rate: lock must stay low for two windows and more
        wr(pcs_pkg::ADDR_CTRL, 32'h0000_0004, 4'h1);
        wr(pcs_pkg::ADDR_MUL_LOW, 32'd40, 4'h1);
        wr(pcs_pkg::ADDR_CTRL, 32'h0000_0024, 4'h1);
        n = 0;
        repeat (36000) begin
            @(posedge clk);
            n += int'(lck === 1'b1);
        end
        chk("false lock cycles", 32'd0, 32'(n));
        results();
    end
endmodule
`default_nettype wire
